/* design/p6mux_top.sv */
// Function selector for the two upper pins of port 6.
// Assumes a register master on MCLK_I and pads resolved outside.

`timescale 1ns/100ps

// Notes on behaviour
// - Pin 6 select clear: plain digital I/O
// - Pin 6 select set, input: channel 2 comparator
// - Pin 6 select and direction set: DAC drives
// - Pin 7 no override, select clear: digital I/O
// - Pin 7 no override, select set: channel 3 comparator
// - Level field 15 routes pin 7 to supervisor
module p6mux_top
(
  // Clock and reset
  input  wire logic                          MCLK_I,
  input  wire logic                          RESET_N_I,
  // Register port
  input  wire logic [p6mux_pkg::ADDR_W-1:0]  BUS_ADDR_I,
  input  wire logic [p6mux_pkg::DATA_W-1:0]  BUS_WDATA_I,
  input  wire logic                          BUS_WR_I,
  input  wire logic                          BUS_RD_I,
  output logic      [p6mux_pkg::DATA_W-1:0]  BUS_RDATA_O,
  // Pads, index 0 is pin 6, index 1 is pin 7
  input  wire logic [p6mux_pkg::PINS-1:0]    PAD_I,
  output logic      [p6mux_pkg::PINS-1:0]    PAD_O,
  output logic      [p6mux_pkg::PINS-1:0]    PAD_OE_O,
  // Sensing front end
  input  wire logic                          SENSE_DAC_OUT_I,
  output logic                               SENSE_CH2_CONNECT_O,
  output logic                               SENSE_CH2_COMPARATOR_IN_O,
  output logic                               SENSE_CH3_CONNECT_O,
  output logic                               SENSE_CH3_COMPARATOR_IN_O,
  // Supply supervisor
  output logic                               SUPERVISOR_CONNECT_O,
  output logic                               SUPERVISOR_EXTERNAL_IN_O
);

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  // Shared by both pins; pin 7 alone knows the override.
  function automatic p6mux_pkg::p6mux_mode_e mode_of(
    input logic top_pin,
    input logic sel,
    input logic dir,
    input logic override
  );
    p6mux_pkg::p6mux_mode_e m;
    m = p6mux_pkg::MODE_GPIO_IN;
    if (top_pin && override)
    begin
      m = p6mux_pkg::MODE_SUP_IN;
    end
    else if (!sel)
    begin
      m = dir ? p6mux_pkg::MODE_GPIO_OUT : p6mux_pkg::MODE_GPIO_IN;
    end
    else if (top_pin)
    begin
      m = p6mux_pkg::MODE_CH3_IN;
    end
    else if (dir)
    begin
      m = p6mux_pkg::MODE_DAC_OUT;
    end
    else
    begin
      m = p6mux_pkg::MODE_CH2_IN;
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  p6mux_pkg::p6mux_bus_s                bus;
  p6mux_pkg::p6mux_mode_e               mode6;
  p6mux_pkg::p6mux_mode_e               mode7;
  p6mux_pkg::p6mux_pad_s                pad6_d;
  p6mux_pkg::p6mux_pad_s                pad7_d;
  p6mux_pkg::p6mux_pad_s                pad6_q;
  p6mux_pkg::p6mux_pad_s                pad7_q;
  logic [p6mux_pkg::PINS-1:0]           sync1_q;
  logic [p6mux_pkg::PINS-1:0]           sync2_q;
  logic [p6mux_pkg::PINS-1:0]           out_q;
  logic [p6mux_pkg::PINS-1:0]           out_d;
  logic [p6mux_pkg::PINS-1:0]           dir_q;
  logic [p6mux_pkg::PINS-1:0]           dir_d;
  logic [p6mux_pkg::PINS-1:0]           sel_q;
  logic [p6mux_pkg::PINS-1:0]           sel_d;
  logic [p6mux_pkg::PINS-1:0]           in_q;
  logic [p6mux_pkg::PINS-1:0]           in_d;
  logic [p6mux_pkg::LVL_W-1:0]          lvl_q;
  logic [p6mux_pkg::LVL_W-1:0]          lvl_d;
  logic [p6mux_pkg::DATA_W-1:0]         rdata_q;
  logic [p6mux_pkg::DATA_W-1:0]         rdata_d;
  logic                                 ch2_conn_q;
  logic                                 ch2_conn_d;
  logic                                 ch2_lvl_q;
  logic                                 ch2_lvl_d;
  logic                                 ch3_conn_q;
  logic                                 ch3_conn_d;
  logic                                 ch3_lvl_q;
  logic                                 ch3_lvl_d;
  logic                                 sup_conn_q;
  logic                                 sup_conn_d;
  logic                                 sup_lvl_q;
  logic                                 sup_lvl_d;
  logic                                 override;

  assign bus.addr  = BUS_ADDR_I;
  assign bus.wdata = BUS_WDATA_I;
  assign bus.wr    = BUS_WR_I;
  assign bus.rd    = BUS_RD_I;

  // ------------------------------------------------------------
  // Pad input synchroniser
  // ------------------------------------------------------------
  // Pads are asynchronous; only the second stage feeds logic.
  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= PAD_I;
      sync2_q <= sync1_q;
    end
  end

  // ------------------------------------------------------------
  // Register file, next values
  // ------------------------------------------------------------
  always_comb
  begin
    out_d   = out_q;
    dir_d   = dir_q;
    sel_d   = sel_q;
    lvl_d   = lvl_q;
    rdata_d = p6mux_pkg::RDATA_NONE;
    if (bus.wr)
    begin
      case (bus.addr)
        p6mux_pkg::OFS_OUTPUT:
        begin
          out_d = {bus.wdata[p6mux_pkg::PIN7_BIT], bus.wdata[p6mux_pkg::PIN6_BIT]};
        end
        p6mux_pkg::OFS_DIR:
        begin
          dir_d = {bus.wdata[p6mux_pkg::PIN7_BIT], bus.wdata[p6mux_pkg::PIN6_BIT]};
        end
        p6mux_pkg::OFS_SEL:
        begin
          sel_d = {bus.wdata[p6mux_pkg::PIN7_BIT], bus.wdata[p6mux_pkg::PIN6_BIT]};
        end
        p6mux_pkg::OFS_LEVEL:
        begin
          lvl_d = bus.wdata[p6mux_pkg::LVL_LSB +: p6mux_pkg::LVL_W];
        end
        default:
        begin
          lvl_d = lvl_q;
        end
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        p6mux_pkg::OFS_INPUT:
        begin
          rdata_d[p6mux_pkg::PIN6_BIT] = in_q[0];
          rdata_d[p6mux_pkg::PIN7_BIT] = in_q[1];
        end
        p6mux_pkg::OFS_OUTPUT:
        begin
          rdata_d[p6mux_pkg::PIN6_BIT] = out_q[0];
          rdata_d[p6mux_pkg::PIN7_BIT] = out_q[1];
        end
        p6mux_pkg::OFS_DIR:
        begin
          rdata_d[p6mux_pkg::PIN6_BIT] = dir_q[0];
          rdata_d[p6mux_pkg::PIN7_BIT] = dir_q[1];
        end
        p6mux_pkg::OFS_SEL:
        begin
          rdata_d[p6mux_pkg::PIN6_BIT] = sel_q[0];
          rdata_d[p6mux_pkg::PIN7_BIT] = sel_q[1];
        end
        p6mux_pkg::OFS_LEVEL:
        begin
          rdata_d[p6mux_pkg::LVL_LSB +: p6mux_pkg::LVL_W] = lvl_q;
        end
        default:
        begin
          rdata_d = p6mux_pkg::RDATA_NONE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin routing, next values
  // ------------------------------------------------------------
  // The latch reaches a pad only in digital output mode, so a
  // stale latch value never fights an analog source.
  always_comb
  begin
    override   = (lvl_q == p6mux_pkg::LVL_OVERRIDE);
    mode6      = mode_of(1'b0, sel_q[0], dir_q[0], 1'b0);
    mode7      = mode_of(1'b1, sel_q[1], dir_q[1], override);
    pad6_d     = '0;
    pad7_d     = '0;
    in_d       = '0;
    ch2_conn_d = 1'b0;
    ch2_lvl_d  = 1'b0;
    ch3_conn_d = 1'b0;
    ch3_lvl_d  = 1'b0;
    sup_conn_d = 1'b0;
    sup_lvl_d  = 1'b0;
    case (mode6)
      p6mux_pkg::MODE_GPIO_IN:
      begin
        in_d[0] = sync2_q[0];
      end
      p6mux_pkg::MODE_GPIO_OUT:
      begin
        pad6_d.out = out_q[0];
        pad6_d.oe  = 1'b1;
        in_d[0]    = sync2_q[0];
      end
      p6mux_pkg::MODE_CH2_IN:
      begin
        ch2_conn_d = 1'b1;
        ch2_lvl_d  = sync2_q[0];
      end
      p6mux_pkg::MODE_DAC_OUT:
      begin
        pad6_d.out = SENSE_DAC_OUT_I;
        pad6_d.oe  = 1'b1;
      end
      default:
      begin
        pad6_d = '0;
      end
    endcase
    case (mode7)
      p6mux_pkg::MODE_GPIO_IN:
      begin
        in_d[1] = sync2_q[1];
      end
      p6mux_pkg::MODE_GPIO_OUT:
      begin
        pad7_d.out = out_q[1];
        pad7_d.oe  = 1'b1;
        in_d[1]    = sync2_q[1];
      end
      p6mux_pkg::MODE_CH3_IN:
      begin
        ch3_conn_d = 1'b1;
        ch3_lvl_d  = sync2_q[1];
      end
      p6mux_pkg::MODE_SUP_IN:
      begin
        sup_conn_d = 1'b1;
        sup_lvl_d  = sync2_q[1];
      end
      default:
      begin
        pad7_d = '0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      out_q      <= {p6mux_pkg::RST_OUTPUT[p6mux_pkg::PIN7_BIT], p6mux_pkg::RST_OUTPUT[p6mux_pkg::PIN6_BIT]};
      dir_q      <= {p6mux_pkg::RST_DIR[p6mux_pkg::PIN7_BIT], p6mux_pkg::RST_DIR[p6mux_pkg::PIN6_BIT]};
      sel_q      <= {p6mux_pkg::RST_SEL[p6mux_pkg::PIN7_BIT], p6mux_pkg::RST_SEL[p6mux_pkg::PIN6_BIT]};
      lvl_q      <= p6mux_pkg::RST_LEVEL;
      rdata_q    <= p6mux_pkg::RDATA_NONE;
      in_q       <= '0;
      pad6_q     <= '0;
      pad7_q     <= '0;
      ch2_conn_q <= 1'b0;
      ch2_lvl_q  <= 1'b0;
      ch3_conn_q <= 1'b0;
      ch3_lvl_q  <= 1'b0;
      sup_conn_q <= 1'b0;
      sup_lvl_q  <= 1'b0;
    end
    else
    begin
      out_q      <= out_d;
      dir_q      <= dir_d;
      sel_q      <= sel_d;
      lvl_q      <= lvl_d;
      rdata_q    <= rdata_d;
      in_q       <= in_d;
      pad6_q     <= pad6_d;
      pad7_q     <= pad7_d;
      ch2_conn_q <= ch2_conn_d;
      ch2_lvl_q  <= ch2_lvl_d;
      ch3_conn_q <= ch3_conn_d;
      ch3_lvl_q  <= ch3_lvl_d;
      sup_conn_q <= sup_conn_d;
      sup_lvl_q  <= sup_lvl_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign BUS_RDATA_O               = rdata_q;
  assign PAD_O                     = {pad7_q.out, pad6_q.out};
  assign PAD_OE_O                  = {pad7_q.oe, pad6_q.oe};
  assign SENSE_CH2_CONNECT_O       = ch2_conn_q;
  assign SENSE_CH2_COMPARATOR_IN_O = ch2_lvl_q;
  assign SENSE_CH3_CONNECT_O       = ch3_conn_q;
  assign SENSE_CH3_COMPARATOR_IN_O = ch3_lvl_q;
  assign SUPERVISOR_CONNECT_O      = sup_conn_q;
  assign SUPERVISOR_EXTERNAL_IN_O  = sup_lvl_q;

endmodule

/* design/p6mux_pkg.sv */
// Constants, types and register layout for the port 6 upper pin selector.
// Assumes a byte-wide register port and a single 25 MHz clock domain.

package p6mux_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int LVL_W  = 4;
  localparam int PINS   = 2;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_INPUT  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DIR    = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_SEL    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_LEVEL  = 4'h4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PIN6_BIT = 6;
  localparam int PIN7_BIT = 7;
  localparam int LVL_LSB  = 0;

  // ------------------------------------------------------------
  // Values
  // ------------------------------------------------------------
  localparam logic [LVL_W-1:0]  LVL_OVERRIDE = 4'hf;
  localparam logic [DATA_W-1:0] RST_OUTPUT   = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIR      = 8'h00;
  localparam logic [DATA_W-1:0] RST_SEL      = 8'h00;
  localparam logic [LVL_W-1:0]  RST_LEVEL    = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_NONE   = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_GPIO_IN,
    MODE_GPIO_OUT,
    MODE_CH2_IN,
    MODE_DAC_OUT,
    MODE_CH3_IN,
    MODE_SUP_IN
  } p6mux_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } p6mux_bus_s;

  typedef struct packed {
    logic out;
    logic oe;
  } p6mux_pad_s;

endpackage

/* test/p6mux_monitor.sv */
// Checker for the port 6 upper pin selector.
// Assumes one clock domain; sees only the selector's ports.
`timescale 1ns/100ps
module p6mux_monitor
(
  // Clock, reset, register port
  input wire logic       MCLK_I,
  input wire logic       RESET_N_I,
  input wire logic [3:0] BUS_ADDR_I,
  input wire logic [7:0] BUS_WDATA_I,
  input wire logic       BUS_WR_I,
  input wire logic       BUS_RD_I,
  input wire logic [7:0] BUS_RDATA_O,
  // Pads and routing
  input wire logic [1:0] PAD_I,
  input wire logic [1:0] PAD_OE_O,
  input wire logic       SENSE_CH2_CONNECT_O,
  input wire logic       SENSE_CH2_COMPARATOR_IN_O,
  input wire logic       SENSE_CH3_CONNECT_O,
  input wire logic       SUPERVISOR_CONNECT_O,
  input wire logic       SUPERVISOR_EXTERNAL_IN_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sup_route_a: assert property (
    BUS_WR_I && BUS_ADDR_I == p6mux_pkg::OFS_LEVEL && BUS_WDATA_I[3:0] == 4'hf
    |-> ##2 SUPERVISOR_CONNECT_O && !SENSE_CH3_CONNECT_O) else $error("supervisor not routed");
  gpio6_release_a: assert property (
    BUS_WR_I && BUS_ADDR_I == p6mux_pkg::OFS_SEL && !BUS_WDATA_I[6]
    |-> ##2 !SENSE_CH2_CONNECT_O) else $error("pin 6 still on ch2");
  rdata_idle_a: assert property (
    !$past(BUS_RD_I) |-> BUS_RDATA_O == 8'h00) else $error("read data outside slot");
  ch2_excl_a: assert property (
    SENSE_CH2_CONNECT_O |-> !PAD_OE_O[0]) else $error("pin 6 driven as ch2 input");
  ch3_excl_a: assert property (
    SENSE_CH3_CONNECT_O |-> !PAD_OE_O[1] && !SUPERVISOR_CONNECT_O) else $error("pin 7 ch3 clash");
  sup_excl_a: assert property (
    SUPERVISOR_CONNECT_O |-> !PAD_OE_O[1]) else $error("pin 7 driven under supervisor");
  ch2_follow_a: assert property (
    SENSE_CH2_CONNECT_O |-> SENSE_CH2_COMPARATOR_IN_O == $past(PAD_I[0], 3)) else $error("ch2 level wrong");
  sup_follow_a: assert property (
    SUPERVISOR_CONNECT_O |-> SUPERVISOR_EXTERNAL_IN_O == $past(PAD_I[1], 3)) else $error("sup level wrong");
  // ----------------------------------------
  // Covers
  // ----------------------------------------
  ch2_c: cover property (SENSE_CH2_CONNECT_O);
  ch3_c: cover property (SENSE_CH3_CONNECT_O);
  sup_c: cover property (SUPERVISOR_CONNECT_O && PAD_OE_O[0]);
endmodule

/* test/p6mux_front.sv */
// Model of the front end and pin wiring beside the selector.
// Assumes the bench sets the analog source levels and DAC level.
`timescale 1ns/100ps
module p6mux_front
(
  // Clock
  input wire logic       clk_i,
  // Bench controls
  input wire logic [1:0] ext_i,
  input wire logic       dac_i,
  // Selector side
  input wire logic [1:0] pad_o_i,
  input wire logic [1:0] pad_oe_i,
  output logic     [1:0] pad_lvl_o,
  output logic           dac_o
);
  // Released pins show the outside source, never a stale drive
  assign pad_lvl_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_i);
  always_ff @(posedge clk_i) dac_o <= dac_i;
endmodule

/* test/tb_port6_upper_pin_function_select.sv */
// Bench for the port 6 upper pin selector: table rows, then edge cases.
// Assumes the front end model and checker are compiled first.
`timescale 1ns/100ps
module tb_port6_upper_pin_function_select;
  typedef struct packed {
    logic [7:0] sel, dir, out;
    logic [3:0] lvl;
    logic [1:0] ext;
    logic       dac;
    logic [7:0] pins;
    logic [2:0] cmp;
    logic [7:0] inb;
  } p6mux_row_s;
  p6mux_row_s rows [9];
  logic clk, rst_n, wr_s, rd_s, dac_lvl, dac, c2, c2i, c3, c3i, sv, svi;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [1:0] ext, pad_i, pad_o, pad_oe;
  int fails, tests_run;
  p6mux_top dut (.MCLK_I(clk), .RESET_N_I(rst_n), .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata),
    .BUS_WR_I(wr_s), .BUS_RD_I(rd_s), .BUS_RDATA_O(rdata), .PAD_I(pad_i), .PAD_O(pad_o),
    .PAD_OE_O(pad_oe), .SENSE_DAC_OUT_I(dac), .SENSE_CH2_CONNECT_O(c2), .SENSE_CH2_COMPARATOR_IN_O(c2i),
    .SENSE_CH3_CONNECT_O(c3), .SENSE_CH3_COMPARATOR_IN_O(c3i), .SUPERVISOR_CONNECT_O(sv),
    .SUPERVISOR_EXTERNAL_IN_O(svi));
  p6mux_front front (.clk_i(clk), .ext_i(ext), .dac_i(dac_lvl), .pad_o_i(pad_o), .pad_oe_i(pad_oe),
    .pad_lvl_o(pad_i), .dac_o(dac));
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    rd_s <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 rv = rdata;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    fails = 0;
    tests_run = 0;
    {rst_n, wr_s, rd_s, dac_lvl, addr, wdata, ext} = '0;
    rows[0] = '{8'h00, 8'h00, 8'h00, 4'h0, 2'h2, 1'h0, 8'h00, 3'h0, 8'h80};
    rows[1] = '{8'h00, 8'hc0, 8'h40, 4'h0, 2'h0, 1'h0, 8'h68, 3'h0, 8'h40};
    rows[2] = '{8'h40, 8'h00, 8'h00, 4'h0, 2'h3, 1'h0, 8'h04, 3'h4, 8'h80};
    rows[3] = '{8'h40, 8'h40, 8'h40, 4'h0, 2'h0, 1'h0, 8'h20, 3'h0, 8'h00};
    rows[4] = '{8'h40, 8'h40, 8'h00, 4'h0, 2'h0, 1'h1, 8'h28, 3'h0, 8'h00};
    rows[5] = '{8'h80, 8'h80, 8'h80, 4'h0, 2'h3, 1'h0, 8'h02, 3'h2, 8'h40};
    rows[6] = '{8'h00, 8'h80, 8'h80, 4'hf, 2'h2, 1'h0, 8'h01, 3'h1, 8'h00};
    rows[7] = '{8'hc0, 8'hc0, 8'h00, 4'hf, 2'h3, 1'h1, 8'h29, 3'h1, 8'h00};
    rows[8] = '{8'h80, 8'hc0, 8'hc0, 4'he, 2'h1, 1'h0, 8'h2a, 3'h0, 8'h40};
    repeat (5) @(posedge clk);
    #1 chk({pad_oe, pad_o, c2, c3, sv, rdata[0]}, 8'h00);
    rst_n <= 1'h1;
    for (int a = 1; a < 10; a += 1 + 4 * (a / 4))
    begin
      rd(a[3:0]);
      chk(rv, 8'h00);
    end
    foreach (rows[i])
    begin
      wr(p6mux_pkg::OFS_OUTPUT, rows[i].out);
      wr(p6mux_pkg::OFS_DIR, rows[i].dir);
      wr(p6mux_pkg::OFS_SEL, rows[i].sel);
      wr(p6mux_pkg::OFS_LEVEL, {4'h0, rows[i].lvl});
      ext <= rows[i].ext;
      dac_lvl <= rows[i].dac;
      repeat (5) @(posedge clk);
      #1 chk({1'h0, pad_oe, pad_o, c2, c3, sv}, rows[i].pins);
      chk({5'h0, c2i, c3i, svi}, {5'h0, rows[i].cmp});
      rd(p6mux_pkg::OFS_INPUT);
      chk(rv, rows[i].inb);
    end
    // Unused bits read zero, writes to input and unmapped places vanish
    wr(p6mux_pkg::OFS_DIR, 8'hff);
    wr(p6mux_pkg::OFS_INPUT, 8'hff);
    wr(4'h9, 8'hff);
    rd(p6mux_pkg::OFS_DIR);
    chk(rv, 8'hc0);
    rd(4'h9);
    chk(rv, 8'h00);
    // Back-to-back writes then reads
    @(posedge clk);
    wr_s <= 1'h1;
    addr <= p6mux_pkg::OFS_SEL;
    wdata <= 8'h80;
    @(posedge clk);
    addr <= p6mux_pkg::OFS_LEVEL;
    wdata <= 8'hff;
    @(posedge clk);
    wr_s <= 1'h0;
    rd_s <= 1'h1;
    addr <= p6mux_pkg::OFS_SEL;
    @(posedge clk);
    addr <= p6mux_pkg::OFS_LEVEL;
    #1 chk(rdata, 8'h80);
    @(posedge clk);
    rd_s <= 1'h0;
    #1 chk(rdata, 8'h0f);
    @(posedge clk);
    #1 chk({rdata[6:0], sv}, 8'h01);
    // Reset in mid-run drops every route at once
    rst_n <= 1'h0;
    #1 chk({pad_oe, pad_o, c2, c3, sv, c2i}, 8'h00);
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd(p6mux_pkg::OFS_LEVEL);
    chk(rv, 8'h00);
    print_verdict();
  end
endmodule
bind p6mux_top p6mux_monitor mon (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .BUS_ADDR_I(BUS_ADDR_I),
  .BUS_WDATA_I(BUS_WDATA_I), .BUS_WR_I(BUS_WR_I), .BUS_RD_I(BUS_RD_I), .BUS_RDATA_O(BUS_RDATA_O),
  .PAD_I(PAD_I), .PAD_OE_O(PAD_OE_O), .SENSE_CH2_CONNECT_O(SENSE_CH2_CONNECT_O),
  .SENSE_CH2_COMPARATOR_IN_O(SENSE_CH2_COMPARATOR_IN_O), .SENSE_CH3_CONNECT_O(SENSE_CH3_CONNECT_O),
  .SUPERVISOR_CONNECT_O(SUPERVISOR_CONNECT_O), .SUPERVISOR_EXTERNAL_IN_O(SUPERVISOR_EXTERNAL_IN_O));
